//--- rtl/srp_supervisor.sv
// Top of the supervisor reset pulse logic
`timescale 1ns/1ps
`default_nettype none
module srp_supervisor
	import srp_pkg::*;
#(
	parameter srp_cfg_type   CONFIG       = CFG_SINGLE,
	parameter srp_setup_type SETUP_SEL    = SETUP_6S72,
	parameter bit            HAS_EXT_SENSE = 1'b0,
	parameter logic [CNT_W-1:0] TIMEOUT_CNT  = CNT_W'(TIMEOUT_CYC),
	parameter logic [CNT_W-1:0] DEBOUNCE_CNT = CNT_W'(DEBOUNCE_CYC),
	parameter logic [CNT_W-1:0] SETUP_CNT    = CNT_W'(setupCycles(SETUP_SEL))
) (
	input  wire logic sys_clk,                  // Timebase clock
	input  wire logic reset_n,                  // Power-on reset, active low
	input  wire logic vccGood,                  // Primary supply above threshold
	input  wire logic external_supply_sense,    // Adjustable supply above threshold
	input  wire logic extended_manual_input_a,  // Extended manual input, active low
	input  wire logic second_manual_input,      // Second input: low-active extended or high-active immediate
	output logic      resetOut_n                // Reset to processor, active low
);
	import srp_pkg::*;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_ARMED,
		ST_SPENT
	} srp_setup_state_type;

	logic                supplyOk;
	logic                mrA;
	logic                mrB;
	logic                setupHold;
	logic [CNT_W-1:0]    porCnt_reg, porCnt_next;
	logic [CNT_W-1:0]    setupCnt_reg, setupCnt_next;
	logic [CNT_W-1:0]    pulseCnt_reg, pulseCnt_next;
	logic [CNT_W-1:0]    immCnt_reg, immCnt_next;
	logic [CNT_W-1:0]    fallCnt_reg, fallCnt_next;
	srp_setup_state_type setupSt_reg, setupSt_next;
	logic                immLevel_reg, immLevel_next;
	logic                out_reg, out_next;
	logic                setupFire;
	logic                immRise;

	assign supplyOk = vccGood && (!HAS_EXT_SENSE || external_supply_sense);

	srp_rise_filter u_filt_a (
		.sys_clk  (sys_clk),
		.reset_n  (reset_n),
		.rawIn    (extended_manual_input_a),
		.cleanOut (mrA)
	);
	srp_rise_filter u_filt_b (
		.sys_clk  (sys_clk),
		.reset_n  (reset_n),
		.rawIn    (CONFIG == CFG_DUAL ? second_manual_input : 1'b1),
		.cleanOut (mrB)
	);

	// Setup timing condition, both low together in dual mode
	assign setupHold = (CONFIG == CFG_DUAL) ? (!mrA && !mrB) : !mrA;

	always_comb begin
		setupSt_next  = setupSt_reg;
		setupCnt_next = setupCnt_reg;
		setupFire     = 1'b0;
		unique case (setupSt_reg)
			ST_IDLE: begin
				setupCnt_next = '0;
				if (setupHold) begin
					setupSt_next = ST_ARMED;
				end
			end
			ST_ARMED: begin
				if (!setupHold) begin
					setupSt_next = ST_IDLE;
				end else if (setupCnt_reg >= SETUP_CNT - 2) begin
					setupFire    = 1'b1;
					setupSt_next = ST_SPENT;
				end else begin
					setupCnt_next = setupCnt_reg + 1'b1;
				end
			end
			ST_SPENT: begin
				if (!setupHold) begin
					setupSt_next = ST_IDLE;
				end
			end
			default: setupSt_next = ST_IDLE;
		endcase
	end

	// Immediate input: rising edge fires, falling edge is debounced
	always_comb begin
		immLevel_next = immLevel_reg;
		fallCnt_next  = '0;
		if (CONFIG == CFG_IMMEDIATE) begin
			if (second_manual_input) begin
				immLevel_next = 1'b1;
			end else if (immLevel_reg) begin
				if (fallCnt_reg >= DEBOUNCE_CNT - 1) begin
					immLevel_next = 1'b0;
				end else begin
					fallCnt_next = fallCnt_reg + 1'b1;
				end
			end
		end
		immRise = (CONFIG == CFG_IMMEDIATE) && second_manual_input && !immLevel_reg;
	end

	always_comb begin
		porCnt_next   = porCnt_reg;
		pulseCnt_next = pulseCnt_reg;
		immCnt_next   = immCnt_reg;
		out_next      = out_reg;
		if (!supplyOk) begin
			porCnt_next   = '0;
			pulseCnt_next = '0;
			immCnt_next   = '0;
			out_next      = 1'b0;
		end else begin
			if (porCnt_reg < TIMEOUT_CNT) begin
				porCnt_next = porCnt_reg + 1'b1;
			end
			if (setupFire) begin
				pulseCnt_next = TIMEOUT_CNT;
			end else if (pulseCnt_reg != '0) begin
				pulseCnt_next = pulseCnt_reg - 1'b1;
			end
			if (immRise) begin
				immCnt_next = TIMEOUT_CNT;
			end else if (immCnt_reg != '0) begin
				immCnt_next = immCnt_reg - 1'b1;
			end
			// Manual pulses only act with good supplies
			out_next = (porCnt_next >= TIMEOUT_CNT) && (pulseCnt_next == '0) && (immCnt_next == '0);
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			setupSt_reg  <= ST_IDLE;
			setupCnt_reg <= '0;
			porCnt_reg   <= '0;
			pulseCnt_reg <= '0;
			immCnt_reg   <= '0;
			fallCnt_reg  <= '0;
			immLevel_reg <= 1'b0;
			out_reg      <= 1'b0;
		end else begin
			setupSt_reg  <= setupSt_next;
			setupCnt_reg <= setupCnt_next;
			porCnt_reg   <= porCnt_next;
			pulseCnt_reg <= pulseCnt_next;
			immCnt_reg   <= immCnt_next;
			fallCnt_reg  <= fallCnt_next;
			immLevel_reg <= immLevel_next;
			out_reg      <= out_next;
		end
	end

	assign resetOut_n = out_reg;

	// Set by a setup pulse, cleared once the hold is released
	logic heldAfterFire_reg;
	logic heldAfterFire_next;

	always_comb begin
		heldAfterFire_next = (setupFire || heldAfterFire_reg) && setupHold;
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			heldAfterFire_reg <= 1'b0;
		end else begin
			heldAfterFire_reg <= heldAfterFire_next;
		end
	end

	// Timing checks; the cycle values follow the build's parameters
	sequence supplyDrop_s;
		!supplyOk;
	endsequence
	sequence immEdge_s;
		immRise && supplyOk;
	endsequence

	supply_low_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		supplyDrop_s |=> !resetOut_n) else $error("Reset not asserted on bad supply");
	bad_supply_hold_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		!supplyOk |-> !out_next) else $error("Output released with bad supply");
	supply_clear_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		supplyDrop_s |=> pulseCnt_reg == '0 && immCnt_reg == '0) else $error("Manual pulse kept with bad supply");
	por_release_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		$rose(resetOut_n) |-> porCnt_reg >= TIMEOUT_CNT) else $error("Released before timeout");
	por_hold_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		supplyOk && porCnt_reg < TIMEOUT_CNT - 1 |=> !resetOut_n) else $error("Released during power-up timeout");
	setup_fire_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		setupFire && supplyOk |=> !resetOut_n && pulseCnt_reg == TIMEOUT_CNT)
		else $error("Setup pulse missing");
	setup_early_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		setupFire |-> setupCnt_reg == SETUP_CNT - 2) else $error("Setup fired at wrong count");
	setup_abort_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		setupSt_reg == ST_ARMED && !setupHold |=> ##1 setupCnt_reg == '0) else $error("Abandoned setup kept its count");
	single_pulse_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		heldAfterFire_reg |-> !setupFire) else $error("Second pulse without release");
	dual_both_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(CONFIG == CFG_DUAL) && setupSt_reg == ST_ARMED && (mrA || mrB) |=> setupSt_reg == ST_IDLE)
		else $error("Dual setup kept with one input released");

	// Immediate input checks
	imm_assert_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		immEdge_s |=> !resetOut_n ##0 immCnt_reg == TIMEOUT_CNT) else $error("Immediate pulse missing");
	imm_release_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		immCnt_reg == 1 && supplyOk && !immRise && pulseCnt_reg <= 1 && porCnt_reg >= TIMEOUT_CNT |=> resetOut_n)
		else $error("Immediate pulse not released");
	fall_debounce_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		$fell(immLevel_reg) |-> $past(fallCnt_reg) >= DEBOUNCE_CNT - 1) else $error("Falling edge not debounced");
	fall_quiet_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		immLevel_reg && !second_manual_input && fallCnt_reg < DEBOUNCE_CNT - 1 |=> immLevel_reg)
		else $error("Short low dropped the immediate level");
endmodule
`default_nettype wire

//--- rtl/srp_pkg.sv
// Package: constants and types for the supervisor reset pulse logic
// Function
// - The reset output goes low at once when any monitored supply is reported below threshold.
// - After all supplies are good, the reset output stays low for the full timeout, then goes high.
// - An extended manual input resets only after staying low for the setup period less RISE_FILTER_CYC - 1 cycles, then pulses once.
// - In the dual configuration the setup period runs only while both inputs are low together.
// - Each valid extended condition gives one pulse; a new pulse needs a release and a new full hold.
// - Rising transitions of the extended manual inputs are debounced inside the block.
// - A rising edge on the immediate input asserts the reset output at once for the timeout.
// - A new rising edge on the immediate input during the timeout restarts the count when DEBOUNCE_CNT is set below TIMEOUT_CNT.
// - The output is released after a full typical timeout with no new rising edge.
// - Falling transitions of the immediate input are debounced for the typical timeout.
// - A manual low period shorter than the setup period less RISE_FILTER_CYC - 1 cycles never asserts the reset output.
// - The setup period is a build option among 10.08, 6.72, 3.36 and 1.68 seconds.
package srp_pkg;
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam longint unsigned TIMEOUT_MIN_MS = 140;
	localparam longint unsigned TIMEOUT_TYP_MS = 210;
	localparam longint unsigned SETUP_K_MS = 10080;
	localparam longint unsigned SETUP_L_MS = 6720;
	localparam longint unsigned SETUP_S_MS = 3360;
	localparam longint unsigned SETUP_T_MS = 1680;
	localparam longint unsigned NS_PER_MS = 1000000;
	// Typical times round up to whole cycles
	localparam longint unsigned TIMEOUT_CYC = (TIMEOUT_TYP_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam longint unsigned DEBOUNCE_CYC = (TIMEOUT_TYP_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned CNT_W = 32;
	localparam int unsigned RISE_FILTER_CYC = 16;
	typedef enum logic [1:0] {
		SETUP_10S08,
		SETUP_6S72,
		SETUP_3S36,
		SETUP_1S68
	} srp_setup_type;
	typedef enum logic [1:0] {
		CFG_SINGLE,
		CFG_DUAL,
		CFG_IMMEDIATE
	} srp_cfg_type;
	function automatic longint unsigned setupCycles(input srp_setup_type sel);
		longint unsigned ms;
		ms = SETUP_T_MS;
		unique case (sel)
			SETUP_10S08: ms = SETUP_K_MS;
			SETUP_6S72:  ms = SETUP_L_MS;
			SETUP_3S36:  ms = SETUP_S_MS;
			SETUP_1S68:  ms = SETUP_T_MS;
		endcase
		return (ms * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	endfunction
endpackage

//--- rtl/srp_rise_filter.sv
// Rising-edge debounce: output goes high only after input held high for a run
`timescale 1ns/1ps
`default_nettype none
module srp_rise_filter
	import srp_pkg::*;
#(
	parameter logic [CNT_W-1:0] HOLD_CYC = CNT_W'(RISE_FILTER_CYC)
) (
	input  wire logic sys_clk,   // Clock
	input  wire logic reset_n,   // Async reset, active low
	input  wire logic rawIn,     // Raw active-low input
	output logic      cleanOut   // Debounced level
);
	logic [CNT_W-1:0] cnt_reg;
	logic [CNT_W-1:0] cnt_next;
	logic             out_reg;
	logic             out_next;
	always_comb begin
		cnt_next = cnt_reg;
		out_next = out_reg;
		if (!rawIn) begin
			// Low passes through at once
			cnt_next = '0;
			out_next = 1'b0;
		end else if (!out_reg) begin
			if (cnt_reg >= HOLD_CYC - 1) begin
				out_next = 1'b1;
			end else begin
				cnt_next = cnt_reg + 1'b1;
			end
		end
	end
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_reg <= '0;
			out_reg <= 1'b1;
		end else begin
			cnt_reg <= cnt_next;
			out_reg <= out_next;
		end
	end
	assign cleanOut = out_reg;
	rise_delay_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		!out_reg && rawIn && !$past(rawIn) |=> !out_reg) else $error("Filter rose on first high sample");
endmodule
`default_nettype wire

//--- bench/srp_cpu_model.sv
// Processor reset input model: counts reset pulses and measures their length
`timescale 1ns/1ps
`default_nettype none
module srp_cpu_model (
	input  wire logic   sys_clk,    // Clock
	input  wire logic   resetIn_n,  // Reset from supervisor, active low
	output logic [7:0]  pulseCount, // Falling edges seen
	output logic [15:0] lowLen      // Cycles of the last finished low period
);
	logic [15:0] runLen;
	logic        prevLvl;
	initial begin
		pulseCount = '0;
		lowLen = '0;
		runLen = '0;
		prevLvl = 1'b0;
	end
	always @(posedge sys_clk) begin
		if (prevLvl && !resetIn_n) begin
			pulseCount <= pulseCount + 8'h01;
		end
		if (!resetIn_n) begin
			runLen <= runLen + 16'h0001;
		end else if (!prevLvl) begin
			lowLen <= runLen;
			runLen <= '0;
		end
		prevLvl <= resetIn_n;
	end
endmodule
`default_nettype wire

//--- bench/supervisor_reset_pulse_logic_tb_top.sv
// Testbench for the supervisor reset pulse logic
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin n_fail++; \
	$display("BAD %s exp %0h got %0h", nm, ex, got); end end
module supervisor_reset_pulse_logic_tb_top;
	import srp_pkg::*;
	localparam int TO = 20;
	localparam int DB = 8;
	localparam int SU = 40;
	logic sys_clk, reset_n, vccGood, extSense, btnA, btnB, immIn;
	logic rstDual_n, rstImm_n;
	logic [7:0] cntD, cntI, c0;
	logic [15:0] lenD, lenI;
	int n_fail = 0;
	int comparisons = 0;
	srp_supervisor #(.CONFIG(CFG_DUAL), .HAS_EXT_SENSE(1'b1),
		.TIMEOUT_CNT(TO), .DEBOUNCE_CNT(DB), .SETUP_CNT(SU)) dut (
		.sys_clk(sys_clk), .reset_n(reset_n), .vccGood(vccGood), .external_supply_sense(extSense),
		.extended_manual_input_a(btnA), .second_manual_input(btnB), .resetOut_n(rstDual_n));
	srp_supervisor #(.CONFIG(CFG_IMMEDIATE), .TIMEOUT_CNT(TO), .DEBOUNCE_CNT(DB), .SETUP_CNT(SU)) dutImm (
		.sys_clk(sys_clk), .reset_n(reset_n), .vccGood(vccGood), .external_supply_sense(1'b1),
		.extended_manual_input_a(btnA), .second_manual_input(immIn), .resetOut_n(rstImm_n));
	srp_cpu_model cpuD (.sys_clk(sys_clk), .resetIn_n(rstDual_n), .pulseCount(cntD), .lowLen(lenD));
	srp_cpu_model cpuI (.sys_clk(sys_clk), .resetIn_n(rstImm_n), .pulseCount(cntI), .lowLen(lenI));
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	task automatic step(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic t_supply();
		@(posedge sys_clk) extSense <= 1'b0;
		step(3);
		`CHK("drop", 1'b0, rstDual_n)
		@(posedge sys_clk) extSense <= 1'b1;
		step(TO - 3);
		`CHK("hold", 1'b0, rstDual_n)
		step(6);
		`CHK("rise", 1'b1, rstDual_n)
	endtask
	task automatic t_ignore();
		c0 = cntD;
		@(posedge sys_clk) {btnA, btnB} <= 2'b00;
		// The rise filter stretches the seen low, so keep press plus filter under the setup count
		step(SU - RISE_FILTER_CYC - 4);
		@(posedge sys_clk) {btnA, btnB} <= 2'b11;
		step(20);
		`CHK("short", c0, cntD)
		@(posedge sys_clk) btnA <= 1'b0;
		step(SU + 20);
		@(posedge sys_clk) btnA <= 1'b1;
		step(20);
		`CHK("single", c0, cntD)
	endtask
	task automatic t_ext();
		c0 = cntD;
		@(posedge sys_clk) {btnA, btnB} <= 2'b00;
		step(SU - 3);
		`CHK("early", 1'b1, rstDual_n)
		step(6);
		`CHK("fire", 1'b0, rstDual_n)
		step(TO + 10);
		`CHK("once", 8'(c0 + 1), cntD)
		`CHK("len", 1'b1, lenD >= 16'(TO - 1) && lenD <= 16'(TO + 2))
		@(posedge sys_clk) btnA <= 1'b1;
		step(5);
		@(posedge sys_clk) btnA <= 1'b0;
		step(SU + 10);
		`CHK("bounce", 8'(c0 + 1), cntD)
		@(posedge sys_clk) {btnA, btnB} <= 2'b11;
		step(20);
		@(posedge sys_clk) {btnA, btnB} <= 2'b00;
		step(SU + TO + 10);
		`CHK("again", 8'(c0 + 2), cntD)
		@(posedge sys_clk) {btnA, btnB} <= 2'b11;
		step(20);
	endtask
	task automatic t_imm();
		@(posedge sys_clk) immIn <= 1'b1;
		step(2);
		`CHK("imm", 1'b0, rstImm_n)
		@(posedge sys_clk) immIn <= 1'b0;
		step(DB + 2);
		@(posedge sys_clk) immIn <= 1'b1;
		step(TO - 3);
		`CHK("retrig", 1'b0, rstImm_n)
		step(6);
		`CHK("release", 1'b1, rstImm_n)
		c0 = cntI;
		@(posedge sys_clk) immIn <= 1'b0;
		step(2);
		@(posedge sys_clk) immIn <= 1'b1;
		@(posedge sys_clk) immIn <= 1'b0;
		step(TO);
		`CHK("fallbounce", c0, cntI)
		@(posedge sys_clk) vccGood <= 1'b0;
		step(2);
		@(posedge sys_clk) immIn <= 1'b1;
		step(2);
		`CHK("badrise", 1'b0, rstImm_n)
		@(posedge sys_clk) vccGood <= 1'b1;
		step(TO - 3);
		`CHK("badhold", 1'b0, rstImm_n)
		step(6);
		`CHK("badrel", 1'b1, rstImm_n)
		@(posedge sys_clk) immIn <= 1'b0;
	endtask
	task automatic summarize();
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	initial begin
		{reset_n, vccGood, extSense, btnA, btnB, immIn} = 6'b011110;
		repeat (5) @(posedge sys_clk);
		reset_n <= 1'b1;
		step(TO - 3);
		`CHK("powerup", 1'b0, rstDual_n)
		step(6);
		`CHK("powerup", 1'b1, rstDual_n)
		t_supply();
		t_ignore();
		t_ext();
		t_imm();
		summarize();
	end
	initial begin
		repeat (5000) @(posedge sys_clk);
		n_fail++;
		summarize();
	end
endmodule
`default_nettype wire
